// file: iwd_map.svh
/*
 * Constants for the instruction word decoder: opcodes, group bounds,
 * operand field positions and cycle counts.
 * Assumes it is included once by the package and the decoder module.
 */
// Behaviour
// - Accept 24-bit program words; three opcodes span two consecutive words.
// - Top 8 bits of a single word are the opcode; the rest are operands.
// - Every opcode falls into one of five groups.
// - Two-word instructions take operands from both words, 24 bits combined.
// - Second word carries zeros in its top 8 bits.
// - A second word decoded on its own acts as a no-op.
// - One cycle normally; two when a condition is true or flow changes.
// - Branch, indirect call/jump, table access, returns take two or three cycles.
// - Taken skip costs two cycles, three when skipping a two-word instruction.
// - Double-word moves take two cycles.
// - Two-word instructions take two cycles.
// - Register ops decode base, source with mode, destination with mode.
// - File ops decode address plus destination: same file or working zero.
// - Bit position comes from a literal or from the base register.
// - Literal ops use base and literal; destination only when flagged.
// - Multiply ops carry accumulator, pair, prefetches and write-back target.
// - Other signal ops carry accumulator and register or literal shift.
// - Write-back target is register 13 direct or indirect with +2.
// - Multiplier pair field encodes six pairs of registers 4 to 7.
// - Working register fields select one of sixteen.
`ifndef IWD_MAP_SVH
`define IWD_MAP_SVH

// opcodes
`define IWD_OP_NOP 8'h00
`define IWD_OP_BRANCH 8'h01
`define IWD_OP_CALL_IND 8'h02
`define IWD_OP_GOTO_IND 8'h03
`define IWD_OP_RETURN 8'h04
`define IWD_OP_RETFI 8'h05
`define IWD_OP_TBL_RD 8'h06
`define IWD_OP_TBL_WR 8'h07
`define IWD_OP_CALL_LONG 8'h08
`define IWD_OP_GOTO_LONG 8'h09
`define IWD_OP_DO_LOOP 8'h0A
`define IWD_OP_SKIP 8'h0B
`define IWD_OP_COND_BRA 8'h0C
`define IWD_OP_MOV_DBL 8'h0D
// group lower bounds
`define IWD_GRP_LIT 8'h20
`define IWD_GRP_WORKING_ZERO_DEST 8'h40
`define IWD_GRP_FILE 8'h80
`define IWD_GRP_BIT 8'hA0
`define IWD_GRP_MAC 8'hC0
`define IWD_GRP_DSP 8'hE0
// field positions (lsb)
`define IWD_OPC_LSB 16
`define IWD_SRC_LSB 0
`define IWD_DST_LSB 6
`define IWD_BASE_LSB 12
`define IWD_FDEST_BIT 13
`define IWD_BIT_IND_BIT 11
`define IWD_LIT_DSEP_BIT 11
`define IWD_ACC_BIT 15
`define IWD_PAIR_LSB 12
`define IWD_XPF_LSB 8
`define IWD_YPF_LSB 4
`define IWD_SHREG_BIT 14
`define IWD_SHLIT_LSB 4
// cycle counts and multiplier pair count
`define IWD_CYC_ONE 2'h1
`define IWD_CYC_TWO 2'h2
`define IWD_CYC_THREE 2'h3
`define IWD_PAIR_COUNT 3'h6

`endif

// file: iwd_pkg.sv
/*
 * Types for the instruction word decoder.
 * Assumes iwd_map.svh is on the include path.
 */
`include "iwd_map.svh"
package iwd_pkg;
	// operation groups
	typedef enum logic [2:0] {
		GRP_WORD_BYTE, GRP_BIT, GRP_LITERAL, GRP_SIGNAL, GRP_CONTROL
	} iwd_group_type;
	// sequencing phases
	typedef enum logic [1:0] {PH_RUN, PH_WAIT2, PH_STALL} iwd_phase_type;
	// one retired instruction
	typedef struct packed {
		logic valid;
		logic nop;
		iwd_group_type group;
		logic [7:0] opcode;
		logic two_word;
		logic second_bad;
		logic [1:0] cycles;
		logic [3:0] base_reg;
		logic [3:0] source_reg;
		logic [1:0] source_mode;
		logic [3:0] dest_reg;
		logic [1:0] dest_mode;
		logic [12:0] file_addr;
		logic working_zero_dest;
		logic [3:0] bit_pos;
		logic bit_indirect;
		logic dest_present;
		logic [15:0] literal;
		logic acc_b;
		logic [2:0] multiplier_reg_pair;
		logic pair_bad;
		logic [3:0] x_prefetch;
		logic [3:0] y_prefetch;
		logic [3:0] x_dest;
		logic [3:0] y_dest;
		logic accumulator_writeback_target;
		logic shift_from_reg;
		logic [3:0] shift_count_reg;
		logic [23:0] target;
	} iwd_dec_type;
	// whole decoder state
	typedef struct packed {
		iwd_phase_type phase;
		logic [1:0] count;
		logic [1:0] flush;
		logic skip_pend;
		logic [23:0] first;
		iwd_dec_type dec;
	} iwd_state_type;
endpackage : iwd_pkg

// file: iwd_decoder.sv
/*
 * Instruction word decoder: sorts program words into groups, splits
 * operand fields, joins two-word instructions and assigns cycle counts.
 * Assumes one fetched word per enabled cycle, held while stall_o is high,
 * and a condition result valid alongside conditional words.
 */
`timescale 1ns/1ns
`default_nettype none
`include "iwd_map.svh"
module iwd_decoder
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	// fetch side
	input wire logic [23:0] fetch_word_i,
	input wire logic fetch_valid_i,
	input wire logic cond_true_i,
	output logic stall_o,
	// datapath side
	output iwd_pkg::iwd_dec_type dec_o
);
	iwd_pkg::iwd_state_type st_reg;
	iwd_pkg::iwd_state_type st_next;
	logic [7:0] opc;

	// --------------------------------------------------------------
	// field decode
	// --------------------------------------------------------------
	// split one word into group and operand fields
	function automatic iwd_pkg::iwd_dec_type split(input logic [23:0] w);
		iwd_pkg::iwd_dec_type d;
		logic [7:0] o;
		logic [15:0] f;
		d = '0;
		o = w[`IWD_OPC_LSB +: 8];
		f = w[15:0];
		d.valid = 1'b1;
		d.opcode = o;
		d.cycles = `IWD_CYC_ONE;
		d.nop = (o == `IWD_OP_NOP);
		// grouping by opcode range
		if (o < `IWD_GRP_LIT)
			d.group = iwd_pkg::GRP_CONTROL;
		else if (o < `IWD_GRP_WORKING_ZERO_DEST)
			d.group = iwd_pkg::GRP_LITERAL;
		else if (o < `IWD_GRP_BIT)
			d.group = iwd_pkg::GRP_WORD_BYTE;
		else if (o < `IWD_GRP_MAC)
			d.group = iwd_pkg::GRP_BIT;
		else
			d.group = iwd_pkg::GRP_SIGNAL;
		// register fields, sixteen working registers each
		d.base_reg = f[`IWD_BASE_LSB +: 4];
		d.source_reg = f[`IWD_SRC_LSB +: 4];
		d.source_mode = f[`IWD_SRC_LSB+4 +: 2];
		d.dest_reg = f[`IWD_DST_LSB +: 4];
		d.dest_mode = f[`IWD_DST_LSB+4 +: 2];
		// file register form
		if (o >= `IWD_GRP_FILE && o < `IWD_GRP_BIT)
		begin
			d.file_addr = f[12:0];
			d.working_zero_dest = ~f[`IWD_FDEST_BIT];
			d.dest_reg = f[`IWD_FDEST_BIT] ? 4'hF & d.dest_reg : 4'h0;
		end
		// bit form: literal position or base register contents
		if (d.group == iwd_pkg::GRP_BIT)
		begin
			d.bit_indirect = f[`IWD_BIT_IND_BIT];
			d.bit_pos = f[`IWD_BASE_LSB +: 4];
		end
		// literal form: separate destination only when flagged
		if (d.group == iwd_pkg::GRP_LITERAL)
		begin
			d.dest_present = f[`IWD_LIT_DSEP_BIT];
			d.literal = f[`IWD_LIT_DSEP_BIT] ? {9'h000, f[6:0]} : {5'h00, f[10:0]};
			d.dest_reg = f[`IWD_LIT_DSEP_BIT] ? f[10:7] : f[`IWD_BASE_LSB +: 4];
		end
		// multiply class
		if (o >= `IWD_GRP_MAC && o < `IWD_GRP_DSP)
		begin
			d.acc_b = f[`IWD_ACC_BIT];
			d.multiplier_reg_pair = f[`IWD_PAIR_LSB +: 3];
			d.pair_bad = (f[`IWD_PAIR_LSB +: 3] >= `IWD_PAIR_COUNT);
			d.x_prefetch = f[`IWD_XPF_LSB +: 4];
			d.y_prefetch = f[`IWD_YPF_LSB +: 4];
			d.x_dest = {2'h1, f[3:2]};
			d.y_dest = {2'h1, f[1:0]};
			d.accumulator_writeback_target = o[0];
		end
		// non-multiplying signal class
		if (o >= `IWD_GRP_DSP)
		begin
			d.acc_b = f[`IWD_ACC_BIT];
			d.shift_from_reg = f[`IWD_SHREG_BIT];
			d.shift_count_reg = f[3:0];
			d.literal = {{10{f[`IWD_SHLIT_LSB+5]}}, f[`IWD_SHLIT_LSB +: 6]};
		end
		d.two_word = (o == `IWD_OP_CALL_LONG) || (o == `IWD_OP_GOTO_LONG)
			|| (o == `IWD_OP_DO_LOOP);
		return d;
	endfunction : split

	// cycles of single-word multi-cycle operations
	function automatic logic [1:0] base_cycles(input logic [7:0] o);
		case (o)
			`IWD_OP_BRANCH, `IWD_OP_CALL_IND, `IWD_OP_GOTO_IND: return `IWD_CYC_TWO;
			`IWD_OP_RETURN, `IWD_OP_RETFI: return `IWD_CYC_THREE;
			`IWD_OP_TBL_RD, `IWD_OP_TBL_WR: return `IWD_CYC_TWO;
			`IWD_OP_MOV_DBL: return `IWD_CYC_TWO;
			default: return `IWD_CYC_ONE;
		endcase
	endfunction : base_cycles

	// --------------------------------------------------------------
	// sequencing
	// --------------------------------------------------------------
	assign opc = fetch_word_i[`IWD_OPC_LSB +: 8];

	// next state
	always_comb
	begin
		st_next = st_reg;
		st_next.dec.valid = 1'b0;
		if (st_reg.phase == iwd_pkg::PH_STALL)
		begin
			st_next.count = st_reg.count - 2'h1;
			if (st_reg.count == 2'h1)
				st_next.phase = iwd_pkg::PH_RUN;
		end
		else if (fetch_valid_i && st_reg.flush != 2'h0)
		begin
			// suppressed word retires as a no-op
			st_next.dec = '0;
			st_next.dec.valid = 1'b1;
			st_next.dec.nop = 1'b1;
			st_next.dec.group = iwd_pkg::GRP_CONTROL;
			st_next.dec.cycles = `IWD_CYC_ONE;
			st_next.skip_pend = 1'b0;
			// a skipped two-word instruction also drops its second word
			if (st_reg.skip_pend && (opc == `IWD_OP_CALL_LONG
				|| opc == `IWD_OP_GOTO_LONG || opc == `IWD_OP_DO_LOOP))
				st_next.flush = st_reg.flush;
			else
				st_next.flush = st_reg.flush - 2'h1;
		end
		else if (fetch_valid_i && st_reg.phase == iwd_pkg::PH_WAIT2)
		begin
			// join with the held first word
			st_next.dec = split(st_reg.first);
			st_next.dec.target = {fetch_word_i[7:0], st_reg.first[15:0]};
			st_next.dec.second_bad = (fetch_word_i[23:16] != 8'h00);
			st_next.dec.cycles = `IWD_CYC_TWO;
			st_next.phase = iwd_pkg::PH_RUN;
		end
		else if (fetch_valid_i)
		begin
			st_next.dec = split(fetch_word_i);
			st_next.dec.cycles = base_cycles(opc);
			if (st_next.dec.two_word)
			begin
				st_next.dec.valid = 1'b0;
				st_next.first = fetch_word_i;
				st_next.phase = iwd_pkg::PH_WAIT2;
			end
			else if (opc == `IWD_OP_SKIP && cond_true_i)
			begin
				st_next.dec.cycles = `IWD_CYC_TWO;
				st_next.flush = 2'h1;
				st_next.skip_pend = 1'b1;
			end
			else if (opc == `IWD_OP_COND_BRA && cond_true_i)
			begin
				st_next.dec.cycles = `IWD_CYC_TWO;
				st_next.flush = 2'h1;
			end
			else if (opc == `IWD_OP_MOV_DBL || opc == `IWD_OP_TBL_RD
				|| opc == `IWD_OP_TBL_WR)
			begin
				// no flow change: hold the fetch instead
				st_next.phase = iwd_pkg::PH_STALL;
				st_next.count = base_cycles(opc) - 2'h1;
			end
			else if (base_cycles(opc) != `IWD_CYC_ONE)
				st_next.flush = base_cycles(opc) - 2'h1;
		end
	end

	// state register
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
			st_reg <= '0;
		else if (clk_en_i)
			st_reg <= st_next;
	end

	assign stall_o = (st_reg.phase == iwd_pkg::PH_STALL);
	assign dec_o = st_reg.dec;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	logic take;
	assign take = clk_en_i && fetch_valid_i && !stall_o && st_reg.flush == 2'h0
		&& st_reg.phase == iwd_pkg::PH_RUN;

	sequence s_nop_word;
		clk_en_i && fetch_valid_i ##1 dec_o.valid && dec_o.nop;
	endsequence

	property p_cond_bra;
		take && opc == `IWD_OP_COND_BRA && cond_true_i
			|=> dec_o.cycles == 2'h2 ##0 (s_nop_word or !(clk_en_i && fetch_valid_i));
	endproperty
	a_cond_bra: assert property (p_cond_bra) else $error("taken branch not two cycles");

	property p_skip_long;
		take && opc == `IWD_OP_SKIP && cond_true_i ##1
			clk_en_i && fetch_valid_i && opc == `IWD_OP_CALL_LONG
			|=> dec_o.nop ##0 st_reg.flush == 2'h1;
	endproperty
	a_skip_long: assert property (p_skip_long) else $error("skip over long word lost");

	property p_movd;
		take && opc == `IWD_OP_MOV_DBL |=> stall_o && dec_o.cycles == 2'h2;
	endproperty
	a_movd: assert property (p_movd) else $error("double move not stalled");

	property p_return;
		take && opc == `IWD_OP_RETURN |=> dec_o.cycles == 2'h3 && st_reg.flush == 2'h2;
	endproperty
	a_return: assert property (p_return) else $error("return cycles wrong");

	property p_two_word;
		take && opc == `IWD_OP_GOTO_LONG ##1 clk_en_i && fetch_valid_i
			|=> dec_o.valid && dec_o.cycles == 2'h2 && dec_o.two_word
			&& dec_o.second_bad == ($past(fetch_word_i[23:16]) != 8'h00);
	endproperty
	a_two_word: assert property (p_two_word) else $error("two-word join wrong");

	property p_lone_second;
		take && opc == 8'h00 |=> dec_o.valid && dec_o.nop;
	endproperty
	a_lone_second: assert property (p_lone_second) else $error("lone second word not nop");

	property p_file_dest;
		take && opc[7:5] == 3'h4
			|=> dec_o.working_zero_dest == !$past(fetch_word_i[`IWD_FDEST_BIT]);
	endproperty
	a_file_dest: assert property (p_file_dest) else $error("file destination wrong");

	property p_pair;
		dec_o.valid && dec_o.opcode[7:5] == 3'h6 |-> dec_o.pair_bad == (dec_o.multiplier_reg_pair > 3'h5);
	endproperty
	a_pair: assert property (p_pair) else $error("pair check wrong");

	property p_group;
		dec_o.valid && !dec_o.nop && dec_o.opcode >= 8'hA0 && dec_o.opcode < 8'hC0
			|-> dec_o.group == iwd_pkg::GRP_BIT;
	endproperty
	a_group: assert property (p_group) else $error("bit group misclassified");

	// a skip taken on the word now being decoded
	sequence s_skip_taken;
		take && opc == `IWD_OP_SKIP && cond_true_i;
	endsequence

	// the skipped word is offered and is a single-word instruction
	sequence s_short_follow;
		clk_en_i && fetch_valid_i && !(opc == `IWD_OP_CALL_LONG
			|| opc == `IWD_OP_GOTO_LONG || opc == `IWD_OP_DO_LOOP);
	endsequence

	property p_skip_short;
		s_skip_taken ##1 s_short_follow
			|=> dec_o.valid && dec_o.nop ##0 st_reg.flush == 2'h0;
	endproperty
	a_skip_short: assert property (p_skip_short) else $error("short skip wrong");

	property p_branch;
		take && opc == `IWD_OP_BRANCH |=> dec_o.cycles == 2'h2 && st_reg.flush == 2'h1;
	endproperty
	a_branch: assert property (p_branch) else $error("branch cycles wrong");

	property p_first_silent;
		take && (opc == `IWD_OP_CALL_LONG || opc == `IWD_OP_GOTO_LONG
			|| opc == `IWD_OP_DO_LOOP) |=> !dec_o.valid && st_reg.phase == iwd_pkg::PH_WAIT2;
	endproperty
	a_first_silent: assert property (p_first_silent) else $error("first word retired");

	property p_flushed;
		clk_en_i && fetch_valid_i && !stall_o && st_reg.flush != 2'h0
			|=> dec_o.valid && dec_o.nop && dec_o.opcode == 8'h00 && dec_o.dest_reg == 4'h0;
	endproperty
	a_flushed: assert property (p_flushed) else $error("flushed word not blank");

	property p_stall_end;
		stall_o && clk_en_i |=> !stall_o;
	endproperty
	a_stall_end: assert property (p_stall_end) else $error("stall too long");

	// a low enable must leave every state bit where it was
	property p_freeze;
		!clk_en_i |=> $stable(st_reg);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");

endmodule : iwd_decoder
`default_nettype wire

// file: iwd_fetch_model.sv
/*
 * Fetch side model: steps a short program of words into the decoder.
 * Assumes the decoder clock enable is high whenever words must be taken.
 */
`timescale 1ns/1ns
`default_nettype none
module iwd_fetch_model
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// bench control
	input wire logic start_i,
	input wire logic [3:0][23:0] prog_i,
	input wire logic [3:0] cond_i,
	input wire logic [2:0] count_i,
	output logic done_o,
	// decoder side
	input wire logic stall_i,
	output logic [23:0] fetch_word_o,
	output logic fetch_valid_o,
	output logic cond_true_o
);
	logic [1:0] idx_reg;
	logic act_reg;

	// advance on each taken word, hold the word while stalled
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			idx_reg <= 2'h0;
			act_reg <= 1'b0;
		end
		else if (start_i)
		begin
			idx_reg <= 2'h0;
			act_reg <= 1'b1;
		end
		else if (act_reg && !stall_i)
		begin
			idx_reg <= idx_reg + 2'h1;
			if ({1'b0, idx_reg} + 3'h1 == count_i)
				act_reg <= 1'b0;
		end
	end

	// idle bus shows the inverse of the last word, never a stale copy
	assign fetch_word_o = act_reg ? prog_i[idx_reg] : ~prog_i[idx_reg - 2'h1];
	assign fetch_valid_o = act_reg;
	assign cond_true_o = act_reg & cond_i[idx_reg];
	assign done_o = !act_reg;
endmodule : iwd_fetch_model
`default_nettype wire

// file: tb_instruction_word_decode_timing.sv
/*
 * Self-checking bench for the instruction word decoder.
 * Assumes iwd_pkg, iwd_decoder and iwd_fetch_model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_instruction_word_decode_timing;
	logic ref_clk;
	logic reset;
	logic clk_en;
	logic start;
	logic [3:0][23:0] prog;
	logic [3:0] cond;
	logic [2:0] cnt;
	logic done;
	logic stall;
	logic fv;
	logic ct;
	logic [23:0] fw;
	iwd_pkg::iwd_dec_type dec;
	iwd_pkg::iwd_dec_type q[$];
	int fail_count;
	int num_checks;
	int stall_cnt;

	iwd_decoder dut (.ref_clk_i(ref_clk), .reset_i(reset), .clk_en_i(clk_en),
		.fetch_word_i(fw), .fetch_valid_i(fv), .cond_true_i(ct), .stall_o(stall), .dec_o(dec));
	iwd_fetch_model fetch (.ref_clk_i(ref_clk), .reset_i(reset), .start_i(start),
		.prog_i(prog), .cond_i(cond), .count_i(cnt), .done_o(done), .stall_i(stall),
		.fetch_word_o(fw), .fetch_valid_o(fv), .cond_true_o(ct));

	// ----------------------------------------
	// clock, monitor and helpers
	// ----------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// collect retired instructions and stalled cycles
	always @(posedge ref_clk)
	begin
		if (!reset && dec.valid === 1'b1)
			q.push_back(dec);
		if (!reset && stall === 1'b1)
			stall_cnt++;
	end

	task automatic ck(input string what, input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : ck

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up

	// run a program of n words and expect ne retirements
	task automatic run(input logic [23:0] a, b, c, d, input logic [3:0] cn,
		input logic [2:0] n, input int ne);
		int k;
		k = 0;
		q.delete();
		stall_cnt = 0;
		prog <= {d, c, b, a};
		cond <= cn;
		cnt <= n;
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		@(posedge ref_clk);
		while (done !== 1'b1 && k < 40)
		begin
			@(posedge ref_clk);
			k++;
		end
		if (k == 40)
		begin
			fail_count++;
			wrap_up();
		end
		repeat (4) @(posedge ref_clk);
		ck("retired", 24'(q.size()), 24'(ne));
	endtask : run

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_flow();
		logic [7:0] op;
		for (int i = 1; i <= 5; i++)
		begin
			op = 8'(i);
			run({op, 16'h0000}, 24'h411234, 24'h411234, 24'h000000, 4'h0, 3'h3, 3);
			ck("fl cyc", q[0].cycles, (op < 8'h04) ? 2'h2 : 2'h3);
			ck("fl grp", q[0].group, iwd_pkg::GRP_CONTROL);
			ck("fl nop1", q[1].nop, 1'b1);
			ck("fl src1", q[1].source_reg, 4'h0);
			ck("fl nop2", q[2].nop, (op < 8'h04) ? 1'b0 : 1'b1);
		end
		$display("t_flow done");
	endtask : t_flow

	task automatic t_stall();
		logic [7:0] op;
		for (int i = 0; i < 3; i++)
		begin
			op = (i == 2) ? 8'h0D : 8'h06 + 8'(i);
			run({op, 16'h0000}, 24'h411234, 24'h0, 24'h0, 4'h0, 3'h2, 2);
			ck("st cyc", q[0].cycles, 2'h2);
			ck("st cnt", 24'(stall_cnt), 24'h1);
			ck("st nop", q[1].nop, 1'b0);
			ck("st src", q[1].source_reg, 4'h4);
		end
		$display("t_stall done");
	endtask : t_stall

	task automatic t_skip();
		logic [7:0] op;
		for (int i = 0; i < 2; i++)
		begin
			op = 8'h0B + 8'(i);
			run({op, 16'h0000}, 24'h411234, 24'h411234, 24'h0, 4'h1, 3'h3, 3);
			ck("sk cyc", q[0].cycles, 2'h2);
			ck("sk nop", q[1].nop, 1'b1);
			ck("sk next", q[2].nop, 1'b0);
			run({op, 16'h0000}, 24'h411234, 24'h0, 24'h0, 4'h0, 3'h2, 2);
			ck("ns cyc", q[0].cycles, 2'h1);
			ck("ns nop", q[1].nop, 1'b0);
		end
		run(24'h0B0000, 24'h081234, 24'h000056, 24'h411234, 4'h1, 3'h4, 4);
		ck("s2 nop1", q[1].nop, 1'b1);
		ck("s2 nop2", q[2].nop, 1'b1);
		ck("s2 next", q[3].nop, 1'b0);
		$display("t_skip done");
	endtask : t_skip

	task automatic t_two();
		logic [7:0] op;
		for (int i = 0; i < 3; i++)
		begin
			op = 8'h08 + 8'(i);
			run({op, 16'h1234}, (i == 2) ? 24'h120056 : 24'h000056, 24'h0, 24'h0, 4'h0, 3'h3, 2);
			ck("tw flag", q[0].two_word, 1'b1);
			ck("tw opc", q[0].opcode, op);
			ck("tw cyc", q[0].cycles, 2'h2);
			ck("tw tgt", q[0].target, 24'h561234);
			ck("tw bad", q[0].second_bad, (i == 2) ? 1'b1 : 1'b0);
			ck("lone nop", q[1].nop, 1'b1);
		end
		$display("t_two done");
	endtask : t_two

	task automatic t_fields();
		run(24'h405A7B, 24'h802123, 24'h800123, 24'hA07800, 4'h0, 3'h4, 4);
		ck("wb grp", q[0].group, iwd_pkg::GRP_WORD_BYTE);
		ck("wb base", q[0].base_reg, 4'h5);
		ck("wb src", {q[0].source_mode, q[0].source_reg}, 6'h3B);
		ck("wb dst", {q[0].dest_mode, q[0].dest_reg}, 6'h29);
		ck("f addr", q[1].file_addr, 13'h0123);
		ck("f same", q[1].working_zero_dest, 1'b0);
		ck("f wz", {q[2].working_zero_dest, q[2].dest_reg}, 5'h10);
		ck("bit grp", q[3].group, iwd_pkg::GRP_BIT);
		ck("bit pos", {q[3].bit_indirect, q[3].bit_pos}, 5'h17);
		run(24'h200A85, 24'hC09ED6, 24'hC16000, 24'hE0C3F7, 4'h0, 3'h4, 4);
		ck("lit grp", q[0].group, iwd_pkg::GRP_LITERAL);
		ck("lit dst", {q[0].dest_present, q[0].dest_reg}, 5'h15);
		ck("lit val", q[0].literal, 16'h0005);
		ck("mac grp", q[1].group, iwd_pkg::GRP_SIGNAL);
		ck("mac acc", {q[1].acc_b, q[1].multiplier_reg_pair}, 4'h9);
		ck("mac pf", {q[1].x_prefetch, q[1].y_prefetch}, 8'hED);
		ck("mac dst", {q[1].x_dest, q[1].y_dest}, 8'h56);
		ck("mac wb", q[1].accumulator_writeback_target, 1'b0);
		ck("pair bad", q[2].pair_bad, 1'b1);
		ck("wb ind", q[2].accumulator_writeback_target, 1'b1);
		ck("sh acc", {q[3].acc_b, q[3].shift_from_reg, q[3].shift_count_reg}, 6'h37);
		ck("sh lit", q[3].literal, 16'hFFFF);
		$display("t_fields done");
	endtask : t_fields

	// a low enable holds the decoder, so offered words are lost
	task automatic t_freeze();
		clk_en <= 1'b0;
		run(24'h411234, 24'h0, 24'h0, 24'h0, 4'h0, 3'h1, 0);
		clk_en <= 1'b1;
		run(24'h405A7B, 24'h0, 24'h0, 24'h0, 4'h0, 3'h1, 1);
		ck("fz src", q[0].source_reg, 4'hB);
		$display("t_freeze done");
	endtask : t_freeze

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		reset = 1'b1;
		clk_en = 1'b1;
		start = 1'b0;
		prog = '0;
		cond = 4'h0;
		cnt = 3'h0;
		fail_count = 0;
		num_checks = 0;
		stall_cnt = 0;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		t_flow();
		t_stall();
		t_skip();
		t_two();
		t_fields();
		t_freeze();
		wrap_up();
	end
endmodule : tb_instruction_word_decode_timing
`default_nettype wire
